//--- stpm_pin_mux.sv
`timescale 1ns/10ps
module stpm_pin_mux #(
    parameter int ADDR_W = 8
) (
    input  wire logic                          core_clk,
    input  wire logic                          resetn,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [ADDR_W-1:0]             s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output logic                               irq,
    // Port D pins (serial port 1)
    input  wire logic [stpm_pkg::SP1_PINS-1:0] port_d_in,
    output logic [stpm_pkg::SP1_PINS-1:0]      port_d_out,
    output logic [stpm_pkg::SP1_PINS-1:0]      port_d_oe,
    // Port E pins (async serial)
    input  wire logic [stpm_pkg::ASI_PINS-1:0] port_e_in,
    output logic [stpm_pkg::ASI_PINS-1:0]      port_e_out,
    output logic [stpm_pkg::ASI_PINS-1:0]      port_e_oe,
    // Timer pins
    input  wire logic [stpm_pkg::TMR_NUM-1:0]  timer_pin_in,
    output logic [stpm_pkg::TMR_NUM-1:0]       timer_pin_out,
    output logic [stpm_pkg::TMR_NUM-1:0]       timer_pin_oe,
    // Serial port 1 side
    input  wire stpm_pkg::stpm_drv_t           sp1_drv,
    input  wire logic                          sp1_tx_active,
    output logic [stpm_pkg::SP1_PINS-1:0]      sp1_pin_level,
    // Async serial side
    input  wire logic                          asi_tx_data,
    input  wire logic                          asi_clk_out,
    input  wire logic                          asi_clk_oe,
    output logic                               asi_rx_data,
    output logic                               asi_clk_in,
    // Timer side
    input  wire logic [stpm_pkg::TMR_NUM-1:0]  tmr_out,
    output logic [stpm_pkg::TMR_NUM-1:0]       tmr_in
);
    import stpm_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [SP1_PINS-1:0] sp1_dir, sp1_func, sp1_dat;   // Port D controls
    logic [ASI_PINS-1:0] asi_dir, asi_func, asi_dat;   // Port E controls
    stpm_tcs_t           tcs [TMR_NUM];                // Timer control words
    logic [TMR_NUM-1:0]  irq_stat, irq_mask;           // Event status and enables
    logic [SP1_PINS-1:0] pd_s1, pd_s2;                 // Port D synchroniser
    logic [ASI_PINS-1:0] pe_s1, pe_s2;                 // Port E synchroniser
    logic [TMR_NUM-1:0]  tp_s1, tp_s2, tp_prev;        // Timer pin sync and history
    logic                aw_full, w_full;              // Write halves held
    logic [ADDR_W-1:0]   aw_addr;                      // Held write address
    logic [31:0]         w_data;                       // Held write data
    logic                w_lane0;                      // Byte lane 0 enabled

    // Next values
    logic [SP1_PINS-1:0] next_sp1_dir, next_sp1_func, next_sp1_dat;
    logic [ASI_PINS-1:0] next_asi_dir, next_asi_func, next_asi_dat;
    stpm_tcs_t           next_tcs [TMR_NUM];
    logic [TMR_NUM-1:0]  next_irq_stat, next_irq_mask;
    logic                next_aw_full, next_w_full, next_w_lane0;
    logic [ADDR_W-1:0]   next_aw_addr;
    logic [31:0]         next_w_data, next_rdata;
    logic                next_bvalid, next_rvalid, next_arready;
    logic [1:0]          next_bresp, next_rresp;
    logic [SP1_PINS-1:0] next_pd_out, next_pd_oe;
    logic [ASI_PINS-1:0] next_pe_out, next_pe_oe;
    logic [TMR_NUM-1:0]  next_tp_out, next_tp_oe, tmr_evt;
    logic                do_write;                     // Both write halves present

    // ------------------------------------------------------------
    // Port D pin drive
    // ------------------------------------------------------------
    // One mux per pin; peripheral drive wins whenever the function bit is set
    for (genvar i = 0; i < SP1_PINS; i++) begin : g_pd
        logic per_oe;
        assign per_oe = (i == SP1_RX_BIT) ? 1'b0 :
                        (i == SP1_TX_BIT) ? sp1_tx_active : sp1_drv.oe[i];
        assign next_pd_oe[i]  = sp1_func[i] ? per_oe : sp1_dir[i];
        assign next_pd_out[i] = sp1_func[i] ? sp1_drv.out[i] : sp1_dat[i];
    end

    // ------------------------------------------------------------
    // Port E and timer pin drive
    // ------------------------------------------------------------
    // GPIO direction when unselected
    always_comb begin
        next_pe_oe  = asi_dir;
        next_pe_out = asi_dat;
        if (asi_func[ASI_RX_BIT]) begin
            next_pe_oe[ASI_RX_BIT] = 1'b0;
        end
        if (asi_func[ASI_TX_BIT]) begin
            next_pe_oe[ASI_TX_BIT]  = 1'b1;
            next_pe_out[ASI_TX_BIT] = asi_tx_data;
        end
        if (asi_func[ASI_CK_BIT]) begin
            next_pe_oe[ASI_CK_BIT]  = asi_clk_oe;
            next_pe_out[ASI_CK_BIT] = asi_clk_out;
        end
    end

    for (genvar t = 0; t < TMR_NUM; t++) begin : g_tm
        logic in_mode;
        assign in_mode = (tcs[t].mode == TM_EVENT) || (tcs[t].mode == TM_MEASURE);
        assign next_tp_oe[t]  = tcs[t].func_en ? !in_mode : tcs[t].gpio_dir;
        assign next_tp_out[t] = tcs[t].func_en ? tmr_out[t] : tcs[t].gpio_out;
        // Rising level on a synchronised timer pin is an event
        assign tmr_evt[t]     = tp_s2[t] && !tp_prev[t];
    end

    // ------------------------------------------------------------
    // Register bus next state
    // ------------------------------------------------------------
    // Write halves may arrive in either order; the response waits for both
    always_comb begin
        next_sp1_dir  = sp1_dir;
        next_sp1_func = sp1_func;
        next_sp1_dat  = sp1_dat;
        next_asi_dir  = asi_dir;
        next_asi_func = asi_func;
        next_asi_dat  = asi_dat;
        next_tcs      = tcs;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_aw_full  = aw_full;
        next_w_full   = w_full;
        next_aw_addr  = aw_addr;
        next_w_data   = w_data;
        next_w_lane0  = w_lane0;
        next_bvalid   = s_axi_bvalid;
        next_bresp    = s_axi_bresp;
        next_rvalid   = s_axi_rvalid;
        next_rresp    = s_axi_rresp;
        next_rdata    = s_axi_rdata;
        do_write      = aw_full && w_full && !s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full  = 1'b1;
            next_w_data  = s_axi_wdata;
            next_w_lane0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // Clear of a status bit happens before the set, so a new event survives
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            case (aw_addr[7:0])
                OFS_SP1_DIR:  if (w_lane0) next_sp1_dir  = w_data[SP1_PINS-1:0];
                OFS_SP1_FUNC: if (w_lane0) next_sp1_func = w_data[SP1_PINS-1:0];
                OFS_SP1_DATA: if (w_lane0) next_sp1_dat  = w_data[SP1_PINS-1:0];
                OFS_ASI_DIR:  if (w_lane0) next_asi_dir  = w_data[ASI_PINS-1:0];
                OFS_ASI_FUNC: if (w_lane0) next_asi_func = w_data[ASI_PINS-1:0];
                OFS_ASI_DATA: if (w_lane0) next_asi_dat  = w_data[ASI_PINS-1:0];
                OFS_TMR0:     if (w_lane0) next_tcs[0]   = stpm_tcs_t'(w_data[7:0]);
                OFS_TMR1:     if (w_lane0) next_tcs[1]   = stpm_tcs_t'(w_data[7:0]);
                OFS_TMR2:     if (w_lane0) next_tcs[2]   = stpm_tcs_t'(w_data[7:0]);
                OFS_IRQ_STAT: if (w_lane0) next_irq_stat = irq_stat & ~w_data[TMR_NUM-1:0];
                OFS_IRQ_MASK: if (w_lane0) next_irq_mask = w_data[TMR_NUM-1:0];
                default:      next_bresp = RESP_SLVER;
            endcase
        end
        next_irq_stat = next_irq_stat | tmr_evt;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        // Read data is captured at the address handshake
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            case (s_axi_araddr[7:0])
                OFS_SP1_DIR:  next_rdata[SP1_PINS-1:0] = sp1_dir;
                OFS_SP1_FUNC: next_rdata[SP1_PINS-1:0] = sp1_func;
                OFS_SP1_DATA: next_rdata[SP1_PINS-1:0] = pd_s2;
                OFS_ASI_DIR:  next_rdata[ASI_PINS-1:0] = asi_dir;
                OFS_ASI_FUNC: next_rdata[ASI_PINS-1:0] = asi_func;
                OFS_ASI_DATA: next_rdata[ASI_PINS-1:0] = pe_s2;
                OFS_TMR0:     next_rdata[TCS_LVL:0]    = {tp_s2[0], tcs[0]};
                OFS_TMR1:     next_rdata[TCS_LVL:0]    = {tp_s2[1], tcs[1]};
                OFS_TMR2:     next_rdata[TCS_LVL:0]    = {tp_s2[2], tcs[2]};
                OFS_IRQ_STAT: next_rdata[TMR_NUM-1:0]  = irq_stat;
                OFS_IRQ_MASK: next_rdata[TMR_NUM-1:0]  = irq_mask;
                default:      next_rresp = RESP_SLVER;
            endcase
        end
        next_arready = !next_rvalid;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset leaves every pin a GPIO input with all functions off
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sp1_dir       <= RST_REG[SP1_PINS-1:0];
            sp1_func      <= RST_REG[SP1_PINS-1:0];
            sp1_dat       <= RST_REG[SP1_PINS-1:0];
            asi_dir       <= RST_REG[ASI_PINS-1:0];
            asi_func      <= RST_REG[ASI_PINS-1:0];
            asi_dat       <= RST_REG[ASI_PINS-1:0];
            for (int k = 0; k < TMR_NUM; k++) tcs[k] <= stpm_tcs_t'(RST_REG);
            irq_stat      <= RST_REG[TMR_NUM-1:0];
            irq_mask      <= RST_REG[TMR_NUM-1:0];
            irq           <= 1'b0;
            pd_s1         <= '0;
            pd_s2         <= '0;
            pe_s1         <= '0;
            pe_s2         <= '0;
            tp_s1         <= '0;
            tp_s2         <= '0;
            tp_prev       <= '0;
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= 32'h0000_0000;
            w_lane0       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            port_d_out    <= '0;
            port_d_oe     <= '0;
            port_e_out    <= '0;
            port_e_oe     <= '0;
            timer_pin_out <= '0;
            timer_pin_oe  <= '0;
            sp1_pin_level <= '0;
            asi_rx_data   <= 1'b0;
            asi_clk_in    <= 1'b0;
            tmr_in        <= '0;
        end else begin
            sp1_dir       <= next_sp1_dir;
            sp1_func      <= next_sp1_func;
            sp1_dat       <= next_sp1_dat;
            asi_dir       <= next_asi_dir;
            asi_func      <= next_asi_func;
            asi_dat       <= next_asi_dat;
            tcs           <= next_tcs;
            irq_stat      <= next_irq_stat;
            irq_mask      <= next_irq_mask;
            irq           <= |(next_irq_stat & next_irq_mask);
            pd_s1         <= port_d_in;
            pd_s2         <= pd_s1;
            pe_s1         <= port_e_in;
            pe_s2         <= pe_s1;
            tp_s1         <= timer_pin_in;
            tp_s2         <= tp_s1;
            tp_prev       <= tp_s2;
            aw_full       <= next_aw_full;
            w_full        <= next_w_full;
            aw_addr       <= next_aw_addr;
            w_data        <= next_w_data;
            w_lane0       <= next_w_lane0;
            // Halves stay refused until the pending write has been answered
            s_axi_awready <= !next_aw_full && !next_bvalid;
            s_axi_wready  <= !next_w_full && !next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rresp   <= next_rresp;
            s_axi_rdata   <= next_rdata;
            port_d_out    <= next_pd_out;
            port_d_oe     <= next_pd_oe;
            port_e_out    <= next_pe_out;
            port_e_oe     <= next_pe_oe;
            timer_pin_out <= next_tp_out;
            timer_pin_oe  <= next_tp_oe;
            // Pin levels reach the peripherals only after three flops
            sp1_pin_level <= pd_s2;
            asi_rx_data   <= pe_s2[ASI_RX_BIT];
            asi_clk_in    <= pe_s2[ASI_CK_BIT];
            tmr_in        <= tp_s2;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    AST_SP1_RX_IN: assert property (
        sp1_func[SP1_RX_BIT] |=> !port_d_oe[SP1_RX_BIT])
        else $error("receive data pin driven in serial use");
    AST_SP1_TX_OUT: assert property (
        sp1_func[SP1_TX_BIT] && sp1_tx_active |=> port_d_oe[SP1_TX_BIT]
            && port_d_out[SP1_TX_BIT] == $past(sp1_drv.out[SP1_TX_BIT]))
        else $error("transmit data pin not driven while transmitting");
    AST_SP1_GPIO: assert property (
        !sp1_func[SP1_TX_BIT] |=> port_d_oe[SP1_TX_BIT] == $past(sp1_dir[SP1_TX_BIT]))
        else $error("port D GPIO direction not followed");
    AST_ASI_GPIO: assert property (
        !asi_func[ASI_CK_BIT] |=> port_e_oe[ASI_CK_BIT] == $past(asi_dir[ASI_CK_BIT]))
        else $error("port E GPIO direction not followed");
    AST_ASI_FUNC: assert property (
        asi_func[ASI_TX_BIT] && !asi_dir[ASI_TX_BIT] |=> port_e_oe[ASI_TX_BIT])
        else $error("async transmit pin not driven in serial use");
    AST_ASI_CLK: assert property (
        asi_func[ASI_CK_BIT] |=> port_e_oe[ASI_CK_BIT] == $past(asi_clk_oe))
        else $error("async clock pin direction wrong");
    AST_TMR_IN: assert property (
        tcs[0].func_en && tcs[0].mode == TM_MEASURE |=> !timer_pin_oe[0])
        else $error("timer pin driven in measurement mode");
    AST_TMR_OUT: assert property (
        tcs[1].func_en && tcs[1].mode == TM_PWM |=> timer_pin_oe[1])
        else $error("timer pin not driven in pulse mode");
    AST_TMR_RST: assert property (
        $rose(resetn) |-> !timer_pin_oe[2] [*2])
        else $error("timer pin not an input after reset");
    AST_IRQ_EVT: assert property (
        tmr_evt[2] |=> irq_stat[2] && (irq || !irq_mask[2]))
        else $error("timer pin event lost");
endmodule

//--- stpm_pkg.sv
package stpm_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SP1_DIR  = 8'h00; // Serial port 1 GPIO direction
    localparam logic [7:0] OFS_SP1_FUNC = 8'h04; // Serial port 1 function select
    localparam logic [7:0] OFS_SP1_DATA = 8'h08; // Serial port 1 GPIO data / level
    localparam logic [7:0] OFS_ASI_DIR  = 8'h0c; // Async serial GPIO direction
    localparam logic [7:0] OFS_ASI_FUNC = 8'h10; // Async serial function select
    localparam logic [7:0] OFS_ASI_DATA = 8'h14; // Async serial GPIO data / level
    localparam logic [7:0] OFS_TMR0     = 8'h18; // Timer 0 control/status
    localparam logic [7:0] OFS_TMR1     = 8'h1c; // Timer 1 control/status
    localparam logic [7:0] OFS_TMR2     = 8'h20; // Timer 2 control/status
    localparam logic [7:0] OFS_IRQ_STAT = 8'h24; // Sticky pin events, write one to clear
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28; // Event enables

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int         SP1_PINS   = 6;      // Port D pins 0..5
    localparam int         ASI_PINS   = 3;      // Port E pins 0..2
    localparam int         TMR_NUM    = 3;      // Independent timers
    localparam int         SP1_RX_BIT = 4;      // Receive data pin
    localparam int         SP1_TX_BIT = 5;      // Transmit data pin
    localparam int         ASI_RX_BIT = 0;
    localparam int         ASI_TX_BIT = 1;
    localparam int         ASI_CK_BIT = 2;
    localparam int         TCS_LVL    = 8;      // Read-only pin level in timer reg
    localparam logic [7:0] RST_REG    = 8'h00;  // All pins GPIO input after reset
    localparam logic [1:0] RESP_OKAY  = 2'b00;
    localparam logic [1:0] RESP_SLVER = 2'b10;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Timer modes held in the control/status word
    typedef enum logic [2:0] {
        TM_EVENT, TM_MEASURE, TM_WATCHDOG, TM_TIMER, TM_PWM
    } stpm_tmode_t;

    // Low byte of each timer control/status register
    typedef struct packed {
        logic [1:0]  spare;    // Reads back as written
        logic        gpio_out; // Bit 5: GPIO output value
        stpm_tmode_t mode;     // Bits 4:2: timer mode
        logic        func_en;  // Bit 1: pin belongs to the timer
        logic        gpio_dir; // Bit 0: GPIO direction, 1 = output
    } stpm_tcs_t;

    // Drive of one pin group
    typedef struct packed {
        logic [SP1_PINS-1:0] out;
        logic [SP1_PINS-1:0] oe;
    } stpm_drv_t;
endpackage

//--- stpm_ext_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Outside world on the pins
// ------------------------------------------------------------
module stpm_ext_model #(
    parameter int N = 12
) (
    input  wire logic [N-1:0] dev_out,
    input  wire logic [N-1:0] dev_oe,
    input  wire logic [N-1:0] ext_val,
    input  wire logic [N-1:0] ext_oe,
    output logic [N-1:0]      level
);
    // Device drive wins; a line nobody drives floats to the inverse value
    assign level = (dev_oe & dev_out) | (~dev_oe & ext_oe & ext_val)
                 | (~dev_oe & ~ext_oe & ~ext_val);
endmodule

//--- stpm_pin_mux_tb_top.sv
`timescale 1ns/10ps
module stpm_pin_mux_tb_top;
    import stpm_pkg::*;
    // ------------------------------------------------------------
    // Signals and shadow registers
    // ------------------------------------------------------------
    logic        core_clk, resetn, awvalid, wvalid, arvalid, irq, sp1_tx_active;
    logic        awready, wready, bvalid, arready, rvalid, asi_rx_data, asi_clk_in;
    logic        asi_tx_data, asi_clk_out, asi_clk_oe;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, rs;
    logic [5:0]  port_d_out, port_d_oe, sp1_pin_level;
    logic [2:0]  port_e_out, port_e_oe, timer_pin_out, timer_pin_oe, tmr_out, tmr_in;
    logic [11:0] ext_val, ext_oe, lvl, eo, ev;
    stpm_drv_t   sp1_drv;
    int          failures, cmp_count, sh [9];

    stpm_ext_model #(.N(12)) ext (.dev_out({timer_pin_out, port_e_out, port_d_out}),
        .dev_oe({timer_pin_oe, port_e_oe, port_d_oe}), .ext_val(ext_val),
        .ext_oe(ext_oe), .level(lvl));
    stpm_pin_mux dut (.core_clk(core_clk), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .irq(irq), .port_d_in(lvl[5:0]), .port_d_out(port_d_out),
        .port_d_oe(port_d_oe), .port_e_in(lvl[8:6]), .port_e_out(port_e_out),
        .port_e_oe(port_e_oe), .timer_pin_in(lvl[11:9]), .timer_pin_out(timer_pin_out),
        .timer_pin_oe(timer_pin_oe), .sp1_drv(sp1_drv), .sp1_tx_active(sp1_tx_active),
        .sp1_pin_level(sp1_pin_level), .asi_tx_data(asi_tx_data),
        .asi_clk_out(asi_clk_out), .asi_clk_oe(asi_clk_oe), .asi_rx_data(asi_rx_data),
        .asi_clk_in(asi_clk_in), .tmr_out(tmr_out), .tmr_in(tmr_in));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("failures %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Write one word; address and data released as each is taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        if (a < OFS_IRQ_STAT && rs === RESP_OKAY) sh[a[7:2]] = d;
    endtask
    task automatic axr(input logic [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
    endtask
    // Expected drive from shadow registers; waits out the level synchronisers
    task automatic chk_pins;
        logic [5:0] f;
        logic [2:0] g;
        repeat (6) @(posedge core_clk);
        f = sh[1][5:0];
        g = sh[4][2:0];
        eo[5:0] = (~f & sh[0][5:0]) | (f & {sp1_tx_active, 1'b0, sp1_drv.oe[3:0]});
        ev[5:0] = (~f & sh[2][5:0]) | (f & {sp1_drv.out[5], 1'b0, sp1_drv.out[3:0]});
        eo[8:6] = (~g & sh[3][2:0]) | (g & {asi_clk_oe, 2'b10});
        ev[8:6] = (~g & sh[5][2:0]) | (g & {asi_clk_out, asi_tx_data, 1'b0});
        for (int t = 0; t < 3; t++) begin
            eo[9+t] = sh[6+t][1] ? (sh[6+t][4:2] > 1) : sh[6+t][0];
            ev[9+t] = sh[6+t][1] ? tmr_out[t] : sh[6+t][5];
        end
        chk({timer_pin_oe, port_e_oe, port_d_oe}, eo);
        chk({timer_pin_out, port_e_out, port_d_out} & eo, ev & eo);
        chk({tmr_in, asi_clk_in, asi_rx_data, sp1_pin_level}, {lvl[11:8], lvl[6:0]});
    endtask

    // ------------------------------------------------------------
    // Clock, hang guard and sequence
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // About 570 cycles are needed; this span leaves ample margin
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        tally_and_finish();
    end
    initial begin
        resetn = 1'b0;
        {awvalid, wvalid, arvalid, sp1_tx_active, asi_tx_data, asi_clk_out, asi_clk_oe} = '0;
        {awaddr, araddr, wdata, tmr_out, ext_val, ext_oe, sp1_drv} = '0;
        void'($urandom(32'h164d));
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        chk_pins();
        // Random drive and config; timer mode codes rotate through all eight, and
        // odd passes hand every timer pin to its timer so both pin directions are seen
        for (int i = 0; i < 10; i++) begin
            sp1_drv <= stpm_drv_t'(12'($urandom));
            {sp1_tx_active, asi_tx_data, asi_clk_out, asi_clk_oe} <= 4'($urandom);
            tmr_out <= 3'($urandom);
            ext_val <= 12'($urandom);
            ext_oe  <= 12'($urandom);
            for (int r = 0; r < 6; r++) axw(8'(4 * r), $urandom & (r < 3 ? 'h3f : 'h7));
            for (int t = 0; t < 3; t++) begin
                axw(8'(24 + 4 * t), ($urandom & 'he3) | ((i + t) % 8) << 2 | (i % 2) << 1);
            end
            chk_pins();
            // Data registers read back the synchronised pin levels
            for (int r = 0; r < 9; r++) begin
                axr(8'(4 * r));
                if (r == 2) chk(rd, 32'(lvl[5:0]));
                else if (r == 5) chk(rd, 32'(lvl[8:6]));
                else chk(rd & (r > 5 ? 'hff : 'hffffffff), sh[r]);
                if (r > 5) chk(rd[8], lvl[r + 3]);
            end
        end
        // A reset in mid-run must hand every pin back as a GPIO input
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        sh = '{default: 0};
        chk_pins();
        // Timer pin rising events, mask and write-one-to-clear
        for (int t = 0; t < 3; t++) axw(8'(24 + 4 * t), 32'h0);
        ext_oe  <= 12'hfff;
        ext_val <= 12'h000;
        repeat (6) @(posedge core_clk);
        axw(OFS_IRQ_MASK, 32'h5);
        axw(OFS_IRQ_STAT, 32'h7);
        ext_val <= 12'he00;
        repeat (6) @(posedge core_clk);
        axr(OFS_IRQ_STAT);
        chk(rd, 32'h7);
        chk(irq, 1'b1);
        axw(OFS_IRQ_STAT, 32'h5);
        axr(OFS_IRQ_STAT);
        chk(rd, 32'h2);
        chk(irq, 1'b0);
        // Unmapped address answers with an error and reads zero
        axw(8'h40, 32'hff);
        chk(rs, RESP_SLVER);
        axr(8'h40);
        chk(rs, RESP_SLVER);
        chk(rd, 32'h0);
        tally_and_finish();
    end
endmodule
